// file: rtl/cop_exec_pkg.sv
// constants, encodings and register map of the coprocessor/branch/cache execution block
package cop_exec_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DWORD_W = 64;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;
    localparam int DIV_CNT_W = 7;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_RS_LO = 8'h04;
    localparam logic [7:0] OFS_RS_HI = 8'h08;
    localparam logic [7:0] OFS_RT_LO = 8'h0C;
    localparam logic [7:0] OFS_RT_HI = 8'h10;
    localparam logic [7:0] OFS_PC_LO = 8'h14;
    localparam logic [7:0] OFS_PC_HI = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_RES_LO = 8'h24;
    localparam logic [7:0] OFS_RES_HI = 8'h28;
    localparam logic [7:0] OFS_TGT_LO = 8'h2C;
    localparam logic [7:0] OFS_TGT_HI = 8'h30;
    localparam logic [7:0] OFS_RTOP_LO = 8'h34;
    localparam logic [7:0] OFS_RTOP_HI = 8'h38;
    localparam logic [7:0] OFS_RBOT_LO = 8'h3C;
    localparam logic [7:0] OFS_RBOT_HI = 8'h40;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE64_BIT = 1;
    localparam int CTRL_RESTRICT_BIT = 2;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TAKEN_BIT = 1;
    localparam int ST_NULLIFY_BIT = 2;
    localparam int ST_OVF_BIT = 3;
    localparam int ST_RI_BIT = 4;
    localparam int ST_BREAK_BIT = 5;
    localparam int ST_RF_WR_BIT = 6;
    localparam int ST_DONE_BIT = 7;
    localparam int ST_COND_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    // ----------------------------------------------------------------
    // instruction encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [3:0] OP_COP_TOP = 4'h4;
    localparam logic [5:0] OP_BNL = 6'h15;
    localparam logic [5:0] OP_ADDIW = 6'h19;
    localparam logic [5:0] OP_CACHE = 6'h2F;
    localparam logic [5:0] FN_BREAK = 6'h0D;
    localparam logic [5:0] FN_DIVW = 6'h1F;
    localparam logic [5:0] FN_ADDW = 6'h2C;
    localparam logic [4:0] COP_RS_CF = 5'h02;
    localparam logic [4:0] COP_RS_CT = 5'h06;
    localparam logic [4:0] COP_RS_BC = 5'h08;
    localparam logic [1:0] COP_UNIT_THREE = 2'h3;
    localparam int CACHE_CODE_HI = 20;
    localparam int CACHE_CODE_LO = 18;

    typedef enum logic [3:0] {
        CA_NONE,
        CA_I_INDEX_INV,
        CA_D_INDEX_WB_INV,
        CA_LOAD_TAG,
        CA_STORE_TAG,
        CA_D_CREATE_DIRTY,
        CA_HIT_INV,
        CA_I_FILL,
        CA_D_HIT_WB_INV,
        CA_D_HIT_WB,
        CA_D_FILL
    } cache_act_e;
endpackage : cop_exec_pkg

// file: rtl/div_if.sv
// request/answer bundle between the execution block and its divider
`timescale 1ns/1ps
`default_nettype none
interface div_if;
    import cop_exec_pkg::*;
    logic start;
    logic [DWORD_W-1:0] dividend;
    logic [DWORD_W-1:0] divisor;
    logic busy;
    logic done;
    logic [DWORD_W-1:0] quot;
    logic [DWORD_W-1:0] rem;
    modport requester (output start, dividend, divisor, input busy, done, quot, rem);
    modport unit (input start, dividend, divisor, output busy, done, quot, rem);
endinterface : div_if
`default_nettype wire

// file: rtl/dword_divider.sv
// serial restoring unsigned doubleword divider
`timescale 1ns/1ps
`default_nettype none
module dword_divider (
    input wire logic core_clk_in,
    input wire logic rst_in,
    div_if.unit div
);
    import cop_exec_pkg::*;

    logic [DWORD_W-1:0] quot_reg;
    logic [DWORD_W-1:0] rem_reg;
    logic [DWORD_W-1:0] divisor_reg;
    logic [DIV_CNT_W-1:0] cnt_reg;
    logic done_reg;
    logic [DWORD_W:0] partial;
    logic geq;
    logic [DWORD_W:0] diff;

    // ----------------------------------------------------------------
    // one quotient bit per cycle
    // ----------------------------------------------------------------
    assign partial = {rem_reg, quot_reg[DWORD_W-1]};
    assign geq = partial >= {1'b0, divisor_reg};
    assign diff = partial - {1'b0, divisor_reg};

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            quot_reg <= '0;
            rem_reg <= '0;
            divisor_reg <= '0;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else if (div.start && cnt_reg == '0) begin
            quot_reg <= div.dividend;
            rem_reg <= '0;
            divisor_reg <= div.divisor;
            cnt_reg <= DIV_CNT_W'(DWORD_W);
            done_reg <= 1'b0;
        end else if (cnt_reg != '0) begin
            // zero divisor just yields all-ones quotient, no trap
            rem_reg <= geq ? diff[DWORD_W-1:0] : partial[DWORD_W-1:0];
            quot_reg <= {quot_reg[DWORD_W-2:0], geq};
            cnt_reg <= cnt_reg - DIV_CNT_W'(1);
            done_reg <= cnt_reg == DIV_CNT_W'(1);
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign div.busy = cnt_reg != '0;
    assign div.done = done_reg;
    assign div.quot = quot_reg;
    assign div.rem = rem_reg;
endmodule : dword_divider
`default_nettype wire

// file: rtl/cop_branch_cache_dword_exec.sv
// execution block: coprocessor branches, likely branches, break, cache op, cop moves, dword math
`timescale 1ns/1ps
`default_nettype none
module cop_branch_cache_dword_exec (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [cop_exec_pkg::ADDR_W-1:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic write_buffer_empty_in,
    input wire logic fpu_cond_in,
    input wire logic ext_condition_pin_two_in,
    input wire logic ext_condition_pin_three_in,
    output logic cop_ctrl_wr_out,
    output logic cop_ctrl_rd_out,
    output logic cop_op_out,
    output logic [1:0] cop_unit_out,
    output logic [4:0] cop_reg_out,
    output logic [31:0] cop_wdata_out,
    output logic [24:0] cop_fun_out,
    input wire logic [31:0] cop_rdata_in,
    output logic cache_req_out,
    output logic cache_dside_out,
    output cop_exec_pkg::cache_act_e cache_act_out,
    output logic cache_way_out,
    output logic [cop_exec_pkg::DWORD_W-1:0] cache_vaddr_out
);
    import cop_exec_pkg::*;

    typedef enum logic [1:0] {IDLE, EXEC, COP_READ, DIV_WAIT} state_e;

    state_e state_reg;
    logic [31:0] instr_reg;
    logic [DWORD_W-1:0] rs_val_reg;
    logic [DWORD_W-1:0] rt_val_reg;
    logic [DWORD_W-1:0] pc_reg;
    logic mode64_reg;
    logic restrict_reg;
    logic taken_reg;
    logic nullify_reg;
    logic ovf_reg;
    logic ri_reg;
    logic break_reg;
    logic rf_wr_reg;
    logic done_reg;
    logic [DWORD_W-1:0] result_reg;
    logic [DWORD_W-1:0] target_reg;
    logic [DWORD_W-1:0] result_top_reg;
    logic [DWORD_W-1:0] result_bottom_reg;
    logic [3:0] cond_prev_reg;

    div_if div_bus ();

    dword_divider u_div (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .div(div_bus.unit)
    );

    // ----------------------------------------------------------------
    // cache operation decode
    // ----------------------------------------------------------------
    function automatic cache_act_e cache_action(input logic [2:0] code, input logic dside);
        cache_act_e act;
        unique case (code)
            3'h0: act = dside ? CA_D_INDEX_WB_INV : CA_I_INDEX_INV;
            3'h1: act = CA_LOAD_TAG;
            3'h2: act = CA_STORE_TAG;
            3'h3: act = dside ? CA_D_CREATE_DIRTY : CA_NONE;
            3'h4: act = CA_HIT_INV;
            3'h5: act = dside ? CA_D_HIT_WB_INV : CA_I_FILL;
            3'h6: act = dside ? CA_D_HIT_WB : CA_NONE;
            3'h7: act = dside ? CA_D_FILL : CA_NONE;
        endcase
        return act;
    endfunction : cache_action

    // ----------------------------------------------------------------
    // instruction field decode
    // ----------------------------------------------------------------
    wire [5:0] opcode = instr_reg[31:26];
    wire [4:0] rs_field = instr_reg[25:21];
    wire [4:0] rt_field = instr_reg[20:16];
    wire [5:0] funct = instr_reg[5:0];
    wire [1:0] cop_unit = instr_reg[27:26];
    wire [DWORD_W-1:0] sext_off = {{48{instr_reg[15]}}, instr_reg[15:0]};
    wire is_cop = opcode[5:2] == OP_COP_TOP;
    wire is_bc = is_cop && rs_field == COP_RS_BC;
    wire is_cf = is_cop && rs_field == COP_RS_CF;
    wire is_ct = is_cop && rs_field == COP_RS_CT;
    wire is_co = is_cop && rs_field[4];
    wire is_bnl = opcode == OP_BNL;
    wire is_cache = opcode == OP_CACHE;
    wire is_special = opcode == OP_SPECIAL;
    wire is_break = is_special && funct == FN_BREAK;
    wire is_addw = is_special && funct == FN_ADDW;
    wire is_divw = is_special && funct == FN_DIVW;
    wire is_addiw = opcode == OP_ADDIW;
    wire is_dword = is_addw || is_addiw || is_divw;
    wire cop3_move = (is_cf || is_ct || is_co) && cop_unit == COP_UNIT_THREE;
    wire [2:0] cache_code = instr_reg[CACHE_CODE_HI:CACHE_CODE_LO];
    wire cache_dside = rt_field[0];
    cache_act_e cache_act;
    assign cache_act = cache_action(cache_code, cache_dside);
    wire cache_undef = is_cache && cache_act == CA_NONE;

    // ----------------------------------------------------------------
    // condition lines and branch resolution
    // ----------------------------------------------------------------
    wire [3:0] cond_live = {ext_condition_pin_three_in, ext_condition_pin_two_in,
                            fpu_cond_in, write_buffer_empty_in};
    // branch reads the lines as caught by the previous instruction
    wire cond_sel = cond_prev_reg[cop_unit];
    wire bc_cond = rt_field[0] ? cond_sel : ~cond_sel;
    wire bne_cond = rs_val_reg != rt_val_reg;
    wire br_cond = is_bnl ? bne_cond : bc_cond;
    wire br_likely = is_bnl || (is_bc && rt_field[1]);
    wire [DWORD_W-1:0] br_target = pc_reg + {sext_off[DWORD_W-3:0], 2'b00};

    // ----------------------------------------------------------------
    // doubleword arithmetic
    // ----------------------------------------------------------------
    wire [DWORD_W-1:0] addw_sum = rs_val_reg + rt_val_reg;
    // overflow when both operands share a sign and the sum's sign differs from it
    wire addw_ovf = (rs_val_reg[63] == rt_val_reg[63]) && (addw_sum[63] != rs_val_reg[63]);
    wire [DWORD_W-1:0] addiw_sum = rs_val_reg + sext_off;
    wire [DWORD_W-1:0] cache_vaddr = rs_val_reg + sext_off;
    wire raise_ri = (is_dword && restrict_reg) || cop3_move || cache_undef;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    wire bus_wr = psel_in && penable_in && pwrite_in;
    wire idle = state_reg == IDLE;
    wire start_req = bus_wr && paddr_in == OFS_CTRL && pwdata_in[CTRL_START_BIT] && idle;
    logic mapped;
    logic [31:0] rd_word;
    wire [31:0] status_word = {20'h0_0000, cond_live, done_reg, rf_wr_reg, break_reg,
                               ri_reg, ovf_reg, nullify_reg, taken_reg, ~idle};

    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr_in)
            OFS_INSTR: rd_word = instr_reg;
            OFS_RS_LO: rd_word = rs_val_reg[31:0];
            OFS_RS_HI: rd_word = rs_val_reg[63:32];
            OFS_RT_LO: rd_word = rt_val_reg[31:0];
            OFS_RT_HI: rd_word = rt_val_reg[63:32];
            OFS_PC_LO: rd_word = pc_reg[31:0];
            OFS_PC_HI: rd_word = pc_reg[63:32];
            OFS_CTRL: rd_word = {29'h0000_0000, restrict_reg, mode64_reg, 1'b0};
            OFS_STATUS: rd_word = status_word;
            OFS_RES_LO: rd_word = result_reg[31:0];
            OFS_RES_HI: rd_word = result_reg[63:32];
            OFS_TGT_LO: rd_word = target_reg[31:0];
            OFS_TGT_HI: rd_word = target_reg[63:32];
            OFS_RTOP_LO: rd_word = result_top_reg[31:0];
            OFS_RTOP_HI: rd_word = result_top_reg[63:32];
            OFS_RBOT_LO: rd_word = result_bottom_reg[31:0];
            OFS_RBOT_HI: rd_word = result_bottom_reg[63:32];
            default: mapped = 1'b0;
        endcase
    end

    // taken in setup, so it stands the whole access phase
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) prdata_out <= '0;
        else if (psel_in && !penable_in) prdata_out <= pwrite_in ? '0 : rd_word;
    end
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // operands are frozen while an instruction runs
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_reg <= 32'h0000_0000;
            rs_val_reg <= '0;
            rt_val_reg <= '0;
            pc_reg <= '0;
            mode64_reg <= CTRL_RESET[CTRL_MODE64_BIT];
            restrict_reg <= CTRL_RESET[CTRL_RESTRICT_BIT];
        end else if (bus_wr && idle) begin
            if (paddr_in == OFS_INSTR) instr_reg <= pwdata_in;
            if (paddr_in == OFS_RS_LO) rs_val_reg[31:0] <= pwdata_in;
            if (paddr_in == OFS_RS_HI) rs_val_reg[63:32] <= pwdata_in;
            if (paddr_in == OFS_RT_LO) rt_val_reg[31:0] <= pwdata_in;
            if (paddr_in == OFS_RT_HI) rt_val_reg[63:32] <= pwdata_in;
            if (paddr_in == OFS_PC_LO) pc_reg[31:0] <= pwdata_in;
            if (paddr_in == OFS_PC_HI) pc_reg[63:32] <= pwdata_in;
            if (paddr_in == OFS_CTRL) begin
                mode64_reg <= pwdata_in[CTRL_MODE64_BIT];
                restrict_reg <= pwdata_in[CTRL_RESTRICT_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    state_e state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE: if (start_req) state_next = EXEC;
            EXEC: begin
                if (!raise_ri && is_cf) state_next = COP_READ;
                else if (!raise_ri && is_divw) state_next = DIV_WAIT;
                else state_next = IDLE;
            end
            COP_READ: state_next = IDLE;
            DIV_WAIT: if (div_bus.done) state_next = IDLE;
        endcase
    end

    wire exec = state_reg == EXEC;
    wire exec_ok = exec && !raise_ri;
    assign div_bus.start = exec_ok && is_divw;
    assign div_bus.dividend = rs_val_reg;
    assign div_bus.divisor = rt_val_reg;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= IDLE;
            cond_prev_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (exec) cond_prev_reg <= cond_live;
        end
    end

    // ----------------------------------------------------------------
    // outcome flags, cleared when the next instruction starts
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            taken_reg <= 1'b0;
            nullify_reg <= 1'b0;
            ovf_reg <= 1'b0;
            ri_reg <= 1'b0;
            break_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (start_req) begin
            {taken_reg, nullify_reg, ovf_reg, ri_reg, break_reg, done_reg} <= 6'h00;
        end else begin
            if (exec && raise_ri) ri_reg <= 1'b1;
            if (exec_ok && is_break) break_reg <= 1'b1;
            if (exec_ok && (is_bc || is_bnl)) begin
                taken_reg <= br_cond;
                nullify_reg <= br_likely && !br_cond;
            end
            if (exec_ok && is_addw && addw_ovf) ovf_reg <= 1'b1;
            if (state_next == IDLE && !idle) done_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // results
    // ----------------------------------------------------------------
    wire [DWORD_W-1:0] cf_data = mode64_reg ? {{32{cop_rdata_in[31]}}, cop_rdata_in}
                                            : {32'h0000_0000, cop_rdata_in};
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_reg <= '0;
            target_reg <= '0;
            rf_wr_reg <= 1'b0;
            result_top_reg <= '0;
            result_bottom_reg <= '0;
        end else begin
            if (start_req) rf_wr_reg <= 1'b0;
            if (exec_ok && (is_bc || is_bnl)) target_reg <= br_target;
            if (exec_ok && is_addw && !addw_ovf) begin
                result_reg <= addw_sum;
                rf_wr_reg <= 1'b1;
            end
            if (exec_ok && is_addiw) begin
                result_reg <= addiw_sum;
                rf_wr_reg <= 1'b1;
            end
            if (state_reg == COP_READ) begin
                result_reg <= cf_data;
                rf_wr_reg <= 1'b1;
            end
            if (state_reg == DIV_WAIT && div_bus.done) begin
                result_bottom_reg <= div_bus.quot;
                result_top_reg <= div_bus.rem;
            end
        end
    end

    // ----------------------------------------------------------------
    // coprocessor and cache command pulses, one cycle after execution
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cop_ctrl_wr_out <= 1'b0;
            cop_ctrl_rd_out <= 1'b0;
            cop_op_out <= 1'b0;
            cop_unit_out <= 2'h0;
            cop_reg_out <= 5'h00;
            cop_wdata_out <= 32'h0000_0000;
            cop_fun_out <= 25'h000_0000;
            cache_req_out <= 1'b0;
            cache_dside_out <= 1'b0;
            cache_act_out <= CA_NONE;
            cache_way_out <= 1'b0;
            cache_vaddr_out <= '0;
        end else begin
            cop_ctrl_wr_out <= exec_ok && is_ct;
            cop_ctrl_rd_out <= exec_ok && is_cf;
            cop_op_out <= exec_ok && is_co;
            cache_req_out <= exec_ok && is_cache;
            if (exec_ok && (is_ct || is_cf || is_co)) begin
                cop_unit_out <= cop_unit;
                cop_reg_out <= instr_reg[15:11];
                cop_wdata_out <= rt_val_reg[31:0];
                cop_fun_out <= instr_reg[24:0];
            end
            if (exec_ok && is_cache) begin
                cache_dside_out <= cache_dside;
                cache_act_out <= cache_act;
                cache_way_out <= cache_vaddr[0];
                cache_vaddr_out <= cache_vaddr;
            end
        end
    end
endmodule : cop_branch_cache_dword_exec
`default_nettype wire

// file: verification/cop_unit_model.sv
// far-side coprocessor control register model
`timescale 1ns/1ps
`default_nettype none
module cop_unit_model (
    input wire logic core_clk_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [6:0] sel_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    logic [31:0] ctl_reg [0:127];
    always_ff @(posedge core_clk_in) begin
        if (wr_in) begin
            ctl_reg[sel_in] <= wdata_in;
        end
    end
    // idle bus shows the inverse, never stale data
    assign rdata_out = rd_in ? ctl_reg[sel_in] : ~ctl_reg[sel_in];
endmodule : cop_unit_model
`default_nettype wire

// file: verification/cop_exec_assertions.sv
// port-level checks of the execution block
`timescale 1ns/1ps
`default_nettype none
module cop_exec_assertions (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cop_ctrl_wr_out,
    input wire logic cop_ctrl_rd_out,
    input wire logic cop_op_out,
    input wire logic [1:0] cop_unit_out,
    input wire logic cache_req_out,
    input wire logic cache_dside_out,
    input wire cop_exec_pkg::cache_act_e cache_act_out,
    input wire logic cache_way_out,
    input wire logic [cop_exec_pkg::DWORD_W-1:0] cache_vaddr_out
);
    import cop_exec_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_rd3; cop_ctrl_rd_out |-> cop_unit_out != COP_UNIT_THREE; endproperty
    a_rd3: assert property (p_rd3) else $error("read from unit three");
    property p_wr3; cop_ctrl_wr_out |-> cop_unit_out != COP_UNIT_THREE; endproperty
    a_wr3: assert property (p_wr3) else $error("write to unit three");
    property p_op3; cop_op_out |-> cop_unit_out != COP_UNIT_THREE; endproperty
    a_op3: assert property (p_op3) else $error("op on unit three");
    property p_opx; cop_op_out |-> !cache_req_out && !cop_ctrl_wr_out; endproperty
    a_opx: assert property (p_opx) else $error("op touched cache");
    property p_way; cache_req_out |-> cache_way_out == cache_vaddr_out[0]; endproperty
    a_way: assert property (p_way) else $error("way not address lsb");
    property p_pulse; cache_req_out |=> !cache_req_out; endproperty
    a_pulse: assert property (p_pulse) else $error("cache request too long");
    property p_iund; cache_req_out && !cache_dside_out |->
        !(cache_act_out inside {CA_D_CREATE_DIRTY, CA_D_HIT_WB, CA_D_FILL}); endproperty
    a_iund: assert property (p_iund) else $error("data op on icache");
    property p_dsd; cache_req_out && cache_dside_out |->
        !(cache_act_out inside {CA_I_FILL, CA_I_INDEX_INV, CA_NONE}); endproperty
    a_dsd: assert property (p_dsd) else $error("icache op on dcache");
endmodule : cop_exec_assertions
bind cop_branch_cache_dword_exec cop_exec_assertions u_chk (.*);
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cop_exec_pkg::*;
    logic core_clk_in = 0;
    logic rst_in = 1;
    logic [7:0] paddr_in = 0;
    logic psel_in = 0, penable_in = 0, pwrite_in = 0, err;
    logic [31:0] pwdata_in = 0, prdata_out, cop_wdata_out, cop_rdata_in, q, st;
    logic [3:0] cond = 0;
    wire logic write_buffer_empty_in = cond[0];
    wire logic fpu_cond_in = cond[1];
    wire logic ext_condition_pin_two_in = cond[2];
    wire logic ext_condition_pin_three_in = cond[3];
    logic pready_out, pslverr_out, cop_ctrl_wr_out, cop_ctrl_rd_out, cop_op_out;
    logic cache_req_out, cache_dside_out, cache_way_out;
    logic [1:0] cop_unit_out;
    logic [4:0] cop_reg_out;
    logic [24:0] cop_fun_out;
    logic [63:0] cache_vaddr_out, seen_va, q64;
    cache_act_e cache_act_out, seen_act, exp_act;
    cache_act_e ia[8] = '{CA_I_INDEX_INV, CA_LOAD_TAG, CA_STORE_TAG, CA_NONE,
        CA_HIT_INV, CA_I_FILL, CA_NONE, CA_NONE};
    cache_act_e da[8] = '{CA_D_INDEX_WB_INV, CA_LOAD_TAG, CA_STORE_TAG, CA_D_CREATE_DIRTY,
        CA_HIT_INV, CA_D_HIT_WB_INV, CA_D_HIT_WB, CA_D_FILL};
    int num_errors = 0, num_checks = 0, cyc = 0, n_req = 0, n0;
    cop_branch_cache_dword_exec dut (.*);
    cop_unit_model partner (.core_clk_in(core_clk_in), .wr_in(cop_ctrl_wr_out),
        .rd_in(cop_ctrl_rd_out), .sel_in({cop_unit_out, cop_reg_out}),
        .wdata_in(cop_wdata_out), .rdata_out(cop_rdata_in));
    always #10 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cache_req_out) begin
            seen_act <= cache_act_out;
            seen_va <= cache_vaddr_out;
            n_req <= n_req + 1;
        end
        // hang guard, well above the expected run length
        if (cyc == 30000) begin
            num_errors++;
            final_report();
        end
    end
    task final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task chk(input string n, input logic [63:0] e, input logic [63:0] s);
        num_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1) @(posedge core_clk_in);
        q = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask : apb
    task rd64(input logic [7:0] a);
        apb(0, a, 0);
        q64[31:0] = q;
        apb(0, a + 8'h04, 0);
        q64[63:32] = q;
    endtask : rd64
    task run(input logic [31:0] i, input logic [63:0] rs, input logic [63:0] rt,
        input logic [31:0] ctl);
        apb(1, OFS_INSTR, i);
        apb(1, OFS_RS_LO, rs[31:0]);
        apb(1, OFS_RS_HI, rs[63:32]);
        apb(1, OFS_RT_LO, rt[31:0]);
        apb(1, OFS_RT_HI, rt[63:32]);
        apb(1, OFS_CTRL, ctl);
        apb(0, OFS_STATUS, 0);
        while (q[ST_DONE_BIT] !== 1'b1) apb(0, OFS_STATUS, 0);
        st = q;
    endtask : run
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_in <= 0;
        apb(1, OFS_PC_LO, 32'h100);
        apb(0, 8'h80, 0);
        chk("slverr", 1, err);
        run({OP_SPECIAL, 20'h0, FN_ADDW}, 64'h1, 64'h2, 32'h3);
        run({OP_SPECIAL, 20'h0, FN_ADDW}, 64'h7FFF_FFFF_FFFF_FFFF, 64'h1, 32'h3);
        chk("ovf", 1, st[ST_OVF_BIT]);
        rd64(OFS_RES_LO);
        chk("kept", 64'h3, q64);
        run({OP_ADDIW, 10'h0, 16'hFFFF}, 64'h8000_0000_0000_0000, 0, 32'h3);
        chk("noovf", 0, st[ST_OVF_BIT]);
        rd64(OFS_RES_LO);
        chk("addiu", 64'h7FFF_FFFF_FFFF_FFFF, q64);
        run({OP_SPECIAL, 20'h0, FN_ADDW}, 64'h1, 64'h2, 32'h5);
        chk("ri32", 1, st[ST_RI_BIT]);
        run({OP_SPECIAL, 20'h0, FN_BREAK}, 0, 0, 32'h3);
        chk("brk", 1, st[ST_BREAK_BIT]);
        $display("test arithmetic done");
        for (int z = 0; z < 4; z++) begin
            for (int t = 0; t < 2; t++) begin
                cond <= t ? (4'h1 << z[1:0]) : ~(4'h1 << z[1:0]);
                run({OP_ADDIW, 26'h0}, 0, 0, 32'h3);
                cond <= ~cond;
                if (z < 3) run({OP_COP_TOP, z[1:0], COP_RS_BC, 5'h03, 16'hFFFE}, 0, 0, 32'h3);
                else run({OP_BNL, 10'h0, 16'h0004}, 64'h5, 64'h5 + t, 32'h3);
                chk("taken", t, st[ST_TAKEN_BIT]);
                chk("null", !t, st[ST_NULLIFY_BIT]);
                rd64(OFS_TGT_LO);
                if (t) chk("target", (z < 3) ? 64'hF8 : 64'h110, q64);
            end
        end
        $display("test branches done");
        for (int c = 0; c < 16; c++) begin
            n0 = n_req;
            exp_act = c[3] ? da[c[2:0]] : ia[c[2:0]];
            run({OP_CACHE, 5'h0, c[2:0], 1'b0, c[3], 16'hFFFD}, 64'h1000, 0, 32'h3);
            if (exp_act == CA_NONE) begin
                chk("ri", 1, st[ST_RI_BIT]);
                chk("nreq", n0, n_req);
            end else begin
                chk("act", exp_act, seen_act);
                chk("va", 64'hFFD, seen_va);
            end
        end
        run({OP_COP_TOP, 2'h2, COP_RS_CT, 5'h0, 5'h05, 11'h0}, 0, 64'h8000_00A5, 32'h3);
        run({OP_COP_TOP, 2'h2, COP_RS_CF, 5'h0, 5'h05, 11'h0}, 0, 0, 32'h3);
        rd64(OFS_RES_LO);
        chk("cf", 64'hFFFF_FFFF_8000_00A5, q64);
        run({OP_COP_TOP, 2'h3, COP_RS_CT, 21'h0}, 0, 0, 32'h3);
        chk("ct3", 1, st[ST_RI_BIT]);
        for (int u = 2; u < 4; u++) begin
            run({OP_COP_TOP, u[1:0], 1'b1, 25'h12345}, 0, 0, 32'h3);
            chk("cop", u == 3, st[ST_RI_BIT]);
        end
        chk("fun", 64'h12345, cop_fun_out);
        run({OP_SPECIAL, 20'h0, FN_DIVW}, 64'hFFFF_FFFF_FFFF_FFFF, 64'h10, 32'h3);
        rd64(OFS_RBOT_LO);
        chk("quot", 64'h0FFF_FFFF_FFFF_FFFF, q64);
        rd64(OFS_RTOP_LO);
        chk("rem", 64'hF, q64);
        $display("test cache and cop done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
